// File: shared/asc_pkg.sv
// constants, carrier structs and helper functions of the async serial core
package asc_pkg;

   // ==========================================================
   // widths and depths
   localparam int unsigned ASC_BAUD_W = 16;
   localparam int unsigned ASC_DATA_W = 9;
   localparam int unsigned ASC_FIFO_DEPTH = 8;

   // ==========================================================
   // bit-time counts, 16 sampling ticks per bit
   localparam logic [3:0] ASC_SUB_LAST = 4'hF;
   localparam logic [3:0] ASC_FRAME8 = 4'hA;
   localparam logic [3:0] ASC_FRAME9 = 4'hB;
   localparam logic [3:0] ASC_NDATA8 = 4'h8;
   localparam logic [3:0] ASC_NDATA9 = 4'h9;
   localparam logic [3:0] ASC_MARK_BITS = 4'h1;
   localparam logic [2:0] ASC_HIST_ONES = 3'h7;

   // sample index is the sample number minus one
   localparam logic [3:0] ASC_RT1 = 4'h0;
   localparam logic [3:0] ASC_RT3 = 4'h2;
   localparam logic [3:0] ASC_RT5 = 4'h4;
   localparam logic [3:0] ASC_RT7 = 4'h6;
   localparam logic [3:0] ASC_RT8 = 4'h7;
   localparam logic [3:0] ASC_RT9 = 4'h8;
   localparam logic [3:0] ASC_RT10 = 4'h9;
   localparam logic [3:0] ASC_RT16 = 4'hF;

   // ==========================================================
   // states
   typedef enum logic [2:0] {ASC_TX_IDLE, ASC_TX_PRE, ASC_TX_DATA, ASC_TX_BRK, ASC_TX_MARK} asc_tx_st_t;
   typedef enum logic [1:0] {ASC_RX_HUNT, ASC_RX_START, ASC_RX_DATA, ASC_RX_STOP} asc_rx_st_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic serial_unit_enable;
      logic tx_enable;
      logic send_break;
      logic char9_sel;
      logic tx_ninth_bit;
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_full_irq_en;
   } asc_ctrl_t;

   typedef struct packed {
      logic tx_empty_flag;
      logic tx_done_flag;
      logic rx_full_flag;
      logic framing_err_flag;
      logic noise_flag;
      logic overrun_flag;
      logic break_detected_flag;
      logic rx_active_flag;
   } asc_status_t;

   typedef struct packed {
      logic [ASC_BAUD_W-1:0] baud_cnt;
      logic tick;
      asc_tx_st_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_sub;
      logic te_prev;
      logic need_pre;
      logic qidle;
      logic txd;
      logic txd_oe;
      logic rxs1;
      logic rxs2;
      asc_rx_st_t rx_st;
      logic [2:0] rx_hist;
      logic rx_prev;
      logic [3:0] rx_rt;
      logic [3:0] rx_idx;
      logic [2:0] rx_vs;
      logic [2:0] rx_ms;
      logic [8:0] rx_sh;
      logic rx_noise;
      logic rx_last_one;
      logic [7:0] rx_data;
      logic rx_ninth;
      asc_status_t status;
      logic tx_irq;
      logic rx_irq;
   } asc_state_t;

   localparam asc_state_t ASC_STATE_RST = '{tx_st: ASC_TX_IDLE, rx_st: ASC_RX_HUNT, need_pre: 1'h1, txd: 1'h1,
                                            rxs1: 1'h1, rxs2: 1'h1, rx_prev: 1'h1, default: '0};

   // ==========================================================
   // three-sample vote helpers
   function automatic logic asc_maj3(input logic [2:0] s);
      asc_maj3 = (s[2] & s[1]) | (s[2] & s[0]) | (s[1] & s[0]);
   endfunction

   function automatic logic asc_disagree3(input logic [2:0] s);
      asc_disagree3 = (s != 3'h0) && (s != 3'h7);
   endfunction

endpackage

// File: hw/asc_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module asc_fifo
#(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
)
(
   input logic mclk_i,
   input logic resetn_i,
   input logic [WIDTH-1:0] in_data_i,
   input logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input logic out_ready_i
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = AW + 1;

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
      logic in_ready;
      logic out_valid;
   } asc_fifo_state_t;

   logic [WIDTH-1:0] mem [DEPTH];
   asc_fifo_state_t s_q, s_d;
   logic push, pull;

   always_comb
   begin
      s_d = s_q;
      push = in_valid_i && s_q.in_ready;
      pull = out_ready_i && s_q.out_valid;
      if (push)
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'h1;
      if (pull)
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'h1;
      s_d.cnt = s_q.cnt + CW'(push) - CW'(pull);
      // registered flags keep the full/empty view free of combinational paths
      s_d.in_ready = (s_d.cnt != CW'(DEPTH));
      s_d.out_valid = (s_d.cnt != '0);
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_q <= '{in_ready: 1'h1, default: '0};
      else
         s_q <= s_d;
   end

   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem[s_q.wr] <= in_data_i;
   end

   assign in_ready_o = s_q.in_ready;
   assign out_valid_o = s_q.out_valid;
   assign out_data_o = mem[s_q.rd];

endmodule // asc_fifo

// File: hw/asc_core.sv
// full-duplex asynchronous serial transmitter and receiver core
`timescale 1ns/1ps

module asc_core
(
   input logic mclk_i,
   input logic resetn_i,
   input asc_pkg::asc_ctrl_t ctrl_i,
   input logic [asc_pkg::ASC_BAUD_W-1:0] baud_div_i,
   input logic [7:0] tx_data_i,
   input logic tx_valid_i,
   output logic tx_ready_o,
   input logic rx_read_i,
   input logic rxd_i,
   output logic txd_o,
   output logic txd_oe_o,
   output asc_pkg::asc_status_t status_o,
   output logic [7:0] rx_data_o,
   output logic rx_ninth_bit_o,
   output logic tx_irq_o,
   output logic rx_irq_o
);
   import asc_pkg::*;

   // ==========================================================
   // declarations
   asc_state_t s_q, s_d;
   logic [ASC_DATA_W-1:0] fifo_data;
   logic fifo_valid, pop, bit_end, load, rx_done, rx_brk, start_fail, resync, smp, fe;
   logic [3:0] flen, nbits, rt_n;
   logic [2:0] v3, m3;

   // ==========================================================
   // transmit buffer; the shifter pulls only when it loads a data frame
   asc_fifo
   #(
      .WIDTH(ASC_DATA_W),
      .DEPTH(ASC_FIFO_DEPTH)
   )
   u_tx_fifo
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .in_data_i({ctrl_i.tx_ninth_bit, tx_data_i}),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      pop = 1'h0;
      rx_done = 1'h0;
      rx_brk = 1'h0;
      start_fail = 1'h0;
      fe = 1'h0;
      smp = s_q.rxs2;
      rt_n = s_q.rx_rt + 4'h1;
      v3 = {s_q.rx_vs[2:1], smp};
      m3 = {s_q.rx_ms[2:1], smp};
      flen = ctrl_i.char9_sel ? ASC_FRAME9 : ASC_FRAME8;
      nbits = ctrl_i.char9_sel ? ASC_NDATA9 : ASC_NDATA8;
      bit_end = s_q.tick && (s_q.tx_sub == ASC_SUB_LAST);
      load = (s_q.tx_bits == 4'h0) || (bit_end && (s_q.tx_bits == 4'h1));
      resync = 1'h0;

      // sampling tick at 16x baud
      s_d.tick = (s_q.baud_cnt == baud_div_i);
      s_d.baud_cnt = s_d.tick ? '0 : s_q.baud_cnt + 16'h0001;

      // only the second stage is read by logic
      s_d.rxs1 = rxd_i;
      s_d.rxs2 = s_q.rxs1;

      // software write takes the buffer; a same-cycle hand-over still sets the flag
      if (tx_valid_i && tx_ready_o)
         s_d.status.tx_empty_flag = 1'h0;
      if (rx_read_i)
      begin
         s_d.status.rx_full_flag = 1'h0;
         s_d.status.framing_err_flag = 1'h0;
         s_d.status.noise_flag = 1'h0;
         s_d.status.overrun_flag = 1'h0;
         s_d.status.break_detected_flag = 1'h0;
      end

      if (ctrl_i.serial_unit_enable)
      begin
         // ---------------- transmitter ----------------
         if (s_q.tick)
            s_d.tx_sub = s_q.tx_sub + 4'h1;
         if (bit_end && (s_q.tx_bits != 4'h0))
         begin
            s_d.tx_sh = {1'h1, s_q.tx_sh[10:1]};
            s_d.tx_bits = s_q.tx_bits - 4'h1;
         end
         // enable back on while a character still shifts: it was dropped during it
         if (ctrl_i.tx_enable && !s_q.te_prev && (s_q.tx_bits != 4'h0))
            s_d.qidle = 1'h1;
         s_d.te_prev = ctrl_i.tx_enable;
         if (load)
         begin
            if (s_q.tx_bits == 4'h0)
               s_d.tx_sub = 4'h0;
            if (!ctrl_i.tx_enable)
            begin
               s_d.tx_st = ASC_TX_IDLE;
               s_d.tx_bits = 4'h0;
               s_d.need_pre = 1'h1;
               s_d.qidle = 1'h0;
            end
            else if (s_q.need_pre || s_d.qidle)
            begin
               s_d.tx_st = ASC_TX_PRE;
               s_d.tx_sh = '1;
               s_d.tx_bits = flen;
               s_d.need_pre = 1'h0;
               s_d.qidle = 1'h0;
            end
            else if (ctrl_i.send_break)
            begin
               s_d.tx_st = ASC_TX_BRK;
               s_d.tx_sh = '0;
               s_d.tx_bits = flen;
            end
            else if (s_q.tx_st == ASC_TX_BRK)
            begin
               s_d.tx_st = ASC_TX_MARK;
               s_d.tx_sh = '1;
               s_d.tx_bits = ASC_MARK_BITS;
            end
            else if (fifo_valid)
            begin
               s_d.tx_st = ASC_TX_DATA;
               s_d.tx_sh = ctrl_i.char9_sel ? {1'h1, fifo_data, 1'h0} : {2'h3, fifo_data[7:0], 1'h0};
               s_d.tx_bits = flen;
               pop = 1'h1;
               s_d.status.tx_empty_flag = 1'h1;
            end
            else
            begin
               s_d.tx_st = ASC_TX_IDLE;
               s_d.tx_bits = 4'h0;
            end
         end

         // ---------------- receiver ----------------
         if (s_q.tick)
         begin
            s_d.rx_prev = smp;
            if (s_q.rx_st == ASC_RX_HUNT)
            begin
               s_d.rx_hist = {s_q.rx_hist[1:0], smp};
               if (!smp && (s_q.rx_hist == ASC_HIST_ONES))
               begin
                  s_d.rx_st = ASC_RX_START;
                  s_d.rx_rt = ASC_RT1;
                  s_d.rx_noise = 1'h0;
                  s_d.rx_sh = '0;
                  s_d.rx_idx = 4'h0;
                  s_d.rx_last_one = 1'h0;
               end
            end
            else
            begin
               s_d.rx_rt = rt_n;
               case (rt_n)
                  ASC_RT3: s_d.rx_vs[2] = smp;
                  ASC_RT5: s_d.rx_vs[1] = smp;
                  ASC_RT8: s_d.rx_ms[2] = smp;
                  ASC_RT9: s_d.rx_ms[1] = smp;
                  default: ;
               endcase
               if ((s_q.rx_st == ASC_RX_START) && (rt_n == ASC_RT7))
               begin
                  if (asc_maj3(v3))
                  begin
                     start_fail = 1'h1;
                     s_d.rx_st = ASC_RX_HUNT;
                     s_d.rx_hist = 3'h0;
                  end
                  else if (asc_disagree3(v3))
                     s_d.rx_noise = 1'h1;
               end
               if (rt_n == ASC_RT10)
               begin
                  case (s_q.rx_st)
                     ASC_RX_START:
                     begin
                        if (m3 != 3'h0)
                           s_d.rx_noise = 1'h1;
                     end
                     ASC_RX_DATA:
                     begin
                        s_d.rx_sh[s_q.rx_idx] = asc_maj3(m3);
                        s_d.rx_last_one = asc_maj3(m3);
                        if (asc_disagree3(m3))
                           s_d.rx_noise = 1'h1;
                     end
                     ASC_RX_STOP:
                     begin
                        fe = !asc_maj3(m3);
                        rx_brk = fe && (ctrl_i.char9_sel ? (s_q.rx_sh == 9'h000) : (s_q.rx_sh[7:0] == 8'h00));
                        rx_done = 1'h1;
                        s_d.rx_st = ASC_RX_HUNT;
                        s_d.rx_hist = 3'h0;
                        if (!s_q.status.rx_full_flag || rx_read_i)
                        begin
                           s_d.rx_data = rx_brk ? 8'h00 : s_q.rx_sh[7:0];
                           s_d.rx_ninth = rx_brk ? 1'h0 : (ctrl_i.char9_sel ? s_q.rx_sh[8] : s_q.rx_sh[7]);
                           s_d.status.rx_full_flag = 1'h1;
                        end
                        else
                           s_d.status.overrun_flag = 1'h1;
                        if (fe)
                           s_d.status.framing_err_flag = 1'h1;
                        if (s_q.rx_noise || asc_disagree3(m3))
                           s_d.status.noise_flag = 1'h1;
                        if (rx_brk)
                           s_d.status.break_detected_flag = 1'h1;
                     end
                     default: ;
                  endcase
               end
               // falling edge after a one bit realigns the sample counter
               resync = ((s_q.rx_st == ASC_RX_DATA) || (s_q.rx_st == ASC_RX_STOP)) && s_q.rx_last_one &&
                        s_q.rx_prev && !smp && ((rt_n < ASC_RT8) || (rt_n > ASC_RT10));
               if (resync)
               begin
                  s_d.rx_rt = ASC_RT1;
                  s_d.rx_last_one = 1'h0;
               end
               if ((s_d.rx_st != ASC_RX_HUNT) && ((rt_n == ASC_RT16) || (resync && (rt_n > ASC_RT10))))
               begin
                  case (s_q.rx_st)
                     ASC_RX_START:
                        s_d.rx_st = ASC_RX_DATA;
                     ASC_RX_DATA:
                     begin
                        if (s_q.rx_idx == (nbits - 4'h1))
                           s_d.rx_st = ASC_RX_STOP;
                        else
                           s_d.rx_idx = s_q.rx_idx + 4'h1;
                     end
                     default: ;
                  endcase
               end
            end
         end
      end
      else
      begin
         // disabled: both directions stop and let go of the pins
         s_d.tx_st = ASC_TX_IDLE;
         s_d.tx_bits = 4'h0;
         s_d.need_pre = 1'h1;
         s_d.qidle = 1'h0;
         s_d.te_prev = 1'h0;
         s_d.rx_st = ASC_RX_HUNT;
         s_d.rx_hist = 3'h0;
      end

      s_d.txd = (s_d.tx_bits != 4'h0) ? s_d.tx_sh[0] : 1'h1;
      s_d.txd_oe = ctrl_i.serial_unit_enable;
      // a word taken this cycle shows in the buffer only next cycle, so it counts as pending now
      s_d.status.tx_done_flag = (s_d.tx_bits == 4'h0) && !fifo_valid && !(tx_valid_i && tx_ready_o) &&
                                !s_d.need_pre;
      s_d.status.rx_active_flag = (s_d.rx_st != ASC_RX_HUNT);
      s_d.tx_irq = (s_d.status.tx_empty_flag && ctrl_i.tx_empty_irq_en) ||
                   (s_d.status.tx_done_flag && ctrl_i.tx_done_irq_en);
      s_d.rx_irq = s_d.status.rx_full_flag && ctrl_i.rx_full_irq_en;
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_q <= ASC_STATE_RST;
      else
         s_q <= s_d;
   end

   assign txd_o = s_q.txd;
   assign txd_oe_o = s_q.txd_oe;
   assign status_o = s_q.status;
   assign rx_data_o = s_q.rx_data;
   assign rx_ninth_bit_o = s_q.rx_ninth;
   assign tx_irq_o = s_q.tx_irq;
   assign rx_irq_o = s_q.rx_irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_pre_start;
      ctrl_i.serial_unit_enable && ctrl_i.tx_enable && (s_q.tx_bits == 4'h0) && s_q.need_pre;
   endsequence
   sequence s_break_end;
      ctrl_i.serial_unit_enable && ctrl_i.tx_enable && !ctrl_i.send_break && (s_q.tx_st == ASC_TX_BRK) &&
      bit_end && (s_q.tx_bits == 4'h1);
   endsequence

   property p_preamble;
      s_pre_start |=> (s_q.tx_st == ASC_TX_PRE) && txd_o;
   endproperty
   a_preamble: assert property (p_preamble) else $error("preamble did not open the transmission");

   property p_frame;
      pop && !ctrl_i.char9_sel |=> !txd_o && (s_q.tx_bits == ASC_FRAME8) && s_q.tx_sh[9];
   endproperty
   a_frame: assert property (p_frame) else $error("data frame not framed by start and stop");

   property p_empty;
      pop |=> status_o.tx_empty_flag;
   endproperty
   a_empty: assert property (p_empty) else $error("empty flag missed hand-over");

   property p_idle;
      (s_q.tx_bits == 4'h0) |-> txd_o;
   endproperty
   a_idle: assert property (p_idle) else $error("output not idle high");

   property p_release;
      !ctrl_i.serial_unit_enable |=> !txd_oe_o && txd_o && !status_o.rx_active_flag;
   endproperty
   a_release: assert property (p_release) else $error("pins not released");

   property p_break;
      (s_q.tx_st == ASC_TX_BRK) && (s_q.tx_bits != 4'h0) |-> !txd_o;
   endproperty
   a_break: assert property (p_break) else $error("break character not all zeros");

   property p_mark;
      s_break_end |=> (s_q.tx_st == ASC_TX_MARK) && txd_o;
   endproperty
   a_mark: assert property (p_mark) else $error("no mark after break");

   property p_done;
      status_o.tx_done_flag |-> (s_q.tx_bits == 4'h0) && !fifo_valid;
   endproperty
   a_done: assert property (p_done) else $error("done flag while busy");

   property p_start_fail;
      start_fail |=> (s_q.rx_st == ASC_RX_HUNT) && !status_o.rx_active_flag;
   endproperty
   a_start_fail: assert property (p_start_fail) else $error("bad start bit not rejected");

   property p_break_rx;
      rx_done && rx_brk && !status_o.rx_full_flag |=> (rx_data_o == 8'h00) && !rx_ninth_bit_o &&
                                                   status_o.break_detected_flag && status_o.rx_full_flag;
   endproperty
   a_break_rx: assert property (p_break_rx) else $error("break reception effects missing");

   property p_fe_full;
      $rose(status_o.framing_err_flag) |-> status_o.rx_full_flag;
   endproperty
   a_fe_full: assert property (p_fe_full) else $error("framing error without full flag");

   property p_overrun;
      rx_done && status_o.rx_full_flag && !rx_read_i |=> status_o.overrun_flag && $stable(rx_data_o);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun lost old data");

   property p_full_irq;
      rx_done && !status_o.rx_full_flag |=> status_o.rx_full_flag && (rx_irq_o == $past(ctrl_i.rx_full_irq_en));
   endproperty
   a_full_irq: assert property (p_full_irq) else $error("full flag or request wrong");

endmodule // asc_core

// File: tb/asc_remote.sv
// remote serial partner: frames onto the receive line, decodes the transmit line
`timescale 1ns/1ps
module asc_remote
#(
   parameter int BIT_CLKS = 32
)
(
   input wire logic mclk_i,
   input wire logic line_i,
   input wire logic char9_i,
   output logic rxd_o,
   output logic [9:0] word_o,
   output logic stb_o
);
   initial
   begin
      rxd_o = 1'b1;
      stb_o = 1'b0;
      word_o = '0;
   end
   // ==========================================================
   // decoder, samples each bit in its middle; preamble never starts it
   always
   begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge mclk_i);
      if (line_i === 1'b0)
      begin
         for (int i = 0; i < (char9_i ? 10 : 9); i++)
         begin
            repeat (BIT_CLKS) @(posedge mclk_i);
            word_o[i] <= line_i;
         end
         if (!char9_i)
         begin
            word_o[9] <= 1'b0;
         end
         stb_o <= 1'b1;
         @(posedge mclk_i);
         stb_o <= 1'b0;
      end
   end
   // ==========================================================
   // sender; trailing ones give the receiver its three idle samples
   task automatic send(input logic [8:0] d, input logic nine, input logic stp);
      logic [11:0] f;
      f = nine ? {1'b1, stp, d, 1'b0} : {2'b11, stp, d[7:0], 1'b0};
      for (int k = 0; k < 12; k++)
      begin
         rxd_o <= f[k];
         repeat (BIT_CLKS) @(posedge mclk_i);
      end
   endtask
endmodule // asc_remote

// File: tb/asc_core_tb.sv
// self-checking bench of the async serial core
`timescale 1ns/1ps
module asc_core_tb;
   import asc_pkg::*;
   logic mclk_i, resetn_i, tx_valid_i, tx_ready_o, rx_read_i, rxd_i, txd_o, txd_oe_o, rx_ninth_bit_o, stb;
   logic full_q, ovr_q, line, rx_irq, tx_irq;
   logic [7:0] tx_data_i, rx_data_o;
   logic [9:0] word;
   logic [31:0] seed;
   asc_ctrl_t ctrl;
   asc_status_t status_o;
   logic [16:0] exp_tx[$], exp_rx[$];
   int failures, checks;
   // pull-up on the released output pin
   assign line = txd_oe_o ? txd_o : 1'b1;
   asc_core asc_core_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .ctrl_i(ctrl), .baud_div_i(16'h0001),
      .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_read_i(rx_read_i),
      .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .status_o(status_o), .rx_data_o(rx_data_o),
      .rx_ninth_bit_o(rx_ninth_bit_o), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   asc_remote asc_remote_inst (.mclk_i(mclk_i), .line_i(line), .char9_i(ctrl.char9_sel), .rxd_o(rxd_i),
      .word_o(word), .stb_o(stb));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // drivers; valid stays high between back-to-back writes
   task automatic wr(input logic [7:0] d);
      int n;
      n = 0;
      tx_data_i <= d;
      tx_valid_i <= 1'b1;
      #1;
      while (tx_ready_o !== 1'b1 && n < 1000)
      begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      if (n == 1000)
         failures++;
      @(posedge mclk_i);
   endtask
   task automatic rd;
      rx_read_i <= 1'b1;
      @(posedge mclk_i);
      rx_read_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic drain;
      for (int n = 0; n < 20000 && exp_tx.size() + exp_rx.size() != 0; n++)
         @(posedge mclk_i);
      if (exp_tx.size() + exp_rx.size() != 0)
         failures++;
      repeat (64) @(posedge mclk_i);
   endtask
   // ==========================================================
   // watcher
   always @(posedge mclk_i)
   begin
      full_q <= status_o.rx_full_flag;
      ovr_q <= status_o.overrun_flag;
      if (stb)
         check_val(word, exp_tx.size() != 0 ? exp_tx.pop_front() : 'x);
      if ((status_o.rx_full_flag && !full_q) || (status_o.overrun_flag && !ovr_q))
         check_val({rx_irq, rx_ninth_bit_o, rx_data_o, status_o[5:1]}, exp_rx.pop_front());
   end
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   initial
   begin
      repeat (100000) @(posedge mclk_i);
      failures++;
      tally_and_finish();
   end
   initial
   begin
      logic [7:0] d;
      {ctrl, tx_data_i, tx_valid_i, rx_read_i, resetn_i, full_q, ovr_q} = '0;
      seed = 32'h263E0D11;
      repeat (20) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      #1 check_val({txd_o, txd_oe_o, status_o}, {7'h00, 2'h2, 8'h00});
      ctrl.serial_unit_enable <= 1'b1;
      @(posedge mclk_i);
      ctrl.tx_enable <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         exp_tx.push_back({9'h001, seed[7:0]});
         wr(seed[7:0]);
      end
      tx_valid_i <= 1'b0;
      drain();
      // drop and restore the enable inside a character: one idle queued, no data lost
      seed = xs(seed);
      exp_tx.push_back({9'h001, seed[7:0]});
      wr(seed[7:0]);
      tx_valid_i <= 1'b0;
      repeat (40) @(posedge mclk_i);
      ctrl.tx_enable <= 1'b0;
      @(posedge mclk_i);
      ctrl.tx_enable <= 1'b1;
      seed = xs(seed);
      exp_tx.push_back({9'h001, seed[7:0]});
      wr(seed[7:0]);
      tx_valid_i <= 1'b0;
      drain();
      exp_tx.push_back(17'h00000);
      ctrl.send_break <= 1'b1;
      repeat (4) @(posedge mclk_i);
      ctrl.send_break <= 1'b0;
      drain();
      ctrl.char9_sel <= 1'b1;
      ctrl.tx_ninth_bit <= 1'b1;
      seed = xs(seed);
      exp_tx.push_back({9'h003, seed[7:0]});
      @(posedge mclk_i);
      wr(seed[7:0]);
      tx_valid_i <= 1'b0;
      drain();
      ctrl.char9_sel <= 1'b0;
      ctrl.rx_full_irq_en <= 1'b1;
      d = xs(seed);
      exp_rx.push_back({1'b1, d[7], d, 5'h10});
      asc_remote_inst.send({1'b0, d}, 1'b0, 1'b1);
      exp_rx.push_back({1'b1, d[7], d, 5'h12});
      asc_remote_inst.send(9'h0C3, 1'b0, 1'b1);
      rd();
      exp_rx.push_back({1'b1, 9'h000, 5'h19});
      asc_remote_inst.send(9'h000, 1'b0, 1'b0);
      rd();
      exp_rx.push_back({1'b1, 9'h055, 5'h18});
      asc_remote_inst.send(9'h055, 1'b0, 1'b0);
      rd();
      ctrl.char9_sel <= 1'b1;
      exp_rx.push_back({1'b1, 1'b1, d, 5'h10});
      asc_remote_inst.send({1'b1, d}, 1'b1, 1'b1);
      rd();
      drain();
      ctrl.serial_unit_enable <= 1'b0;
      ctrl.tx_empty_irq_en <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 check_val({txd_oe_o, txd_o}, 17'h00001);
      check_val(tx_irq, 17'h00001);
      tally_and_finish();
   end
endmodule // asc_core_tb
